// ==== core/sdc_channel.sv ====
// Purpose: one serial channel with dma ready pins, ring status and pin float control
// Assumes: apb slave with one wait state; 8 data bits, one stop bit, no parity
// Notes: every pin output comes from a flip-flop and has an enable for floating
//
// Local design decisions: the register offsets and the APB register port.
`include "sdc_params.svh"
module sdc_channel import sdc_pkg::*; #(
  parameter int FIFO_DEPTH = 16,
  parameter int FIFO_AW = 4
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_in_ch0,
  input wire logic ring_indicator_n_ch0,
  input wire logic output_float,
  output logic serial_out_ch0,
  output logic rx_dma_request_n_ch0,
  output logic tx_dma_request_n_ch0,
  output logic [`SDC_MCR_OUT_MSB:0] modem_ctrl_out,
  output logic irq,
  output logic pins_oe
);
  ////////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [7:0] fifo_ctrl_reg;
  logic tx_enable_reg;
  logic [`SDC_MCR_W-1:0] modem_ctrl_reg;
  logic [`SDC_DIV_W-1:0] divisor_reg;
  logic [`SDC_IRQ_W-1:0] irq_stat_reg;
  logic [`SDC_IRQ_W-1:0] irq_mask_reg;
  logic ring_edge_reg;
  logic overrun_reg;
  logic ring_prev_reg;
  logic [31:0] rd_value;
  logic rd_hit;
  logic apb_done;
  logic wr_data, rd_data, wr_fcr, rd_lsr, rd_msr, rd_irq;
  logic sin_s, ring_s, float_s;
  logic fifo_en, mode1, loop_en, rx_line;
  logic rx_push, rx_full, rx_empty, tx_full, tx_empty, tx_pop;
  logic [7:0] rx_head, tx_head;
  logic [FIFO_AW:0] rx_count, tx_count;
  logic [4:0] trig_level;
  sdc_tx_state_t tx_state_reg;
  sdc_rx_state_t rx_state_reg;
  logic [`SDC_DIV_W-1:0] tx_cnt_reg, rx_cnt_reg;
  logic [3:0] tx_bit_reg, rx_bit_reg;
  logic [7:0] tx_shift_reg, rx_shift_reg;
  logic tx_line_reg;
  logic [7:0] timeout_reg;
  logic rx_timeout;
  logic tx_tick;

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and buffers
  sdc_sync #(.W(3), .RST(3'h6)) u_sync ( // line resets to mark: space would fake a start bit
    .mclk(mclk),
    .rstn(rstn),
    .async_in({serial_in_ch0, ring_indicator_n_ch0, output_float}),
    .sync_out({sin_s, ring_s, float_s})
  );

  sdc_fifo #(.W(8), .D(FIFO_DEPTH), .AW(FIFO_AW)) u_rx_fifo (
    .mclk(mclk),
    .rstn(rstn),
    .clr(wr_fcr && pwdata[`SDC_FCR_RX_CLR]),
    .push(rx_push && !rx_full),
    .push_data(rx_shift_reg),
    .pop(rd_data),
    .head(rx_head),
    .count(rx_count),
    .full(),
    .empty(rx_empty)
  );

  sdc_fifo #(.W(8), .D(FIFO_DEPTH), .AW(FIFO_AW)) u_tx_fifo (
    .mclk(mclk),
    .rstn(rstn),
    .clr(wr_fcr && pwdata[`SDC_FCR_TX_CLR]),
    .push(wr_data && !tx_full),
    .push_data(pwdata[7:0]),
    .pop(tx_pop),
    .head(tx_head),
    .count(tx_count),
    .full(),
    .empty(tx_empty)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // mode decode: without fifos the buffers act as one-character holding registers
  assign fifo_en = fifo_ctrl_reg[`SDC_FCR_FIFO_EN];
  assign mode1 = fifo_en && fifo_ctrl_reg[`SDC_FCR_DMA_MODE];
  assign loop_en = modem_ctrl_reg[`SDC_MCR_LOOP];
  assign rx_full = fifo_en ? (rx_count == (FIFO_AW+1)'(FIFO_DEPTH)) : !rx_empty;
  assign tx_full = fifo_en ? (tx_count == (FIFO_AW+1)'(FIFO_DEPTH)) : !tx_empty;
  assign rx_line = loop_en ? tx_line_reg : sin_s;

  // trigger level table
  always_comb begin
    case (fifo_ctrl_reg[`SDC_FCR_TRIG_MSB:`SDC_FCR_TRIG_LSB])
      2'h0: trig_level = `SDC_TRIG_0;
      2'h1: trig_level = `SDC_TRIG_1;
      2'h2: trig_level = `SDC_TRIG_2;
      default: trig_level = `SDC_TRIG_3;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // apb decode; side effects happen only at the completing edge
  assign apb_done = psel && penable && pready;
  assign wr_data = apb_done && pwrite && (paddr == `SDC_OFF_DATA);
  assign rd_data = apb_done && !pwrite && (paddr == `SDC_OFF_DATA);
  assign wr_fcr = apb_done && pwrite && (paddr == `SDC_OFF_FIFO_CTRL);
  assign rd_lsr = apb_done && !pwrite && (paddr == `SDC_OFF_LINE_STAT);
  assign rd_msr = apb_done && !pwrite && (paddr == `SDC_OFF_MODEM_STAT);
  assign rd_irq = apb_done && !pwrite && (paddr == `SDC_OFF_IRQ_STAT);

  // read mux
  always_comb begin
    rd_value = 32'h0000_0000;
    rd_hit = 1'b1;
    case (paddr)
      `SDC_OFF_DATA: rd_value[7:0] = rx_head;
      `SDC_OFF_FIFO_CTRL: rd_value[7:0] = fifo_ctrl_reg;
      `SDC_OFF_CTRL: rd_value[`SDC_CTL_TX_EN] = tx_enable_reg;
      `SDC_OFF_MODEM_CTRL: rd_value[`SDC_MCR_W-1:0] = modem_ctrl_reg;
      `SDC_OFF_LINE_STAT: begin
        rd_value[`SDC_LSR_DATA_READY] = !rx_empty;
        rd_value[`SDC_LSR_OVERRUN] = overrun_reg;
        rd_value[`SDC_LSR_THR_EMPTY] = tx_empty;
        rd_value[`SDC_LSR_TX_EMPTY] = tx_empty && (tx_state_reg == SDC_TX_IDLE);
      end
      `SDC_OFF_MODEM_STAT: begin
        rd_value[`SDC_MSR_RING_EDGE] = ring_edge_reg;
        rd_value[`SDC_MSR_RING_STATE] = !ring_s;
      end
      `SDC_OFF_IRQ_STAT: rd_value[`SDC_IRQ_W-1:0] = irq_stat_reg;
      `SDC_OFF_IRQ_MASK: rd_value[`SDC_IRQ_W-1:0] = irq_mask_reg;
      `SDC_OFF_DIVISOR: rd_value[`SDC_DIV_W-1:0] = divisor_reg;
      default: rd_hit = 1'b0;
    endcase
  end

  // one wait state lets prdata come from a flop
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !rd_hit;
      if (psel && penable && !pready) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_value;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // software-written registers; clear bits of fifo control self-clear
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      fifo_ctrl_reg <= 8'h00;
      tx_enable_reg <= 1'b0;
      modem_ctrl_reg <= `SDC_MCR_RESET;
      irq_mask_reg <= '0;
      divisor_reg <= `SDC_DIV_RESET;
    end else if (apb_done && pwrite) begin
      case (paddr)
        `SDC_OFF_FIFO_CTRL: begin
          fifo_ctrl_reg <= pwdata[7:0];
          fifo_ctrl_reg[`SDC_FCR_RX_CLR] <= 1'b0;
          fifo_ctrl_reg[`SDC_FCR_TX_CLR] <= 1'b0;
        end
        `SDC_OFF_CTRL: tx_enable_reg <= pwdata[`SDC_CTL_TX_EN];
        `SDC_OFF_MODEM_CTRL: modem_ctrl_reg <= pwdata[`SDC_MCR_W-1:0];
        `SDC_OFF_IRQ_MASK: irq_mask_reg <= pwdata[`SDC_IRQ_W-1:0];
        `SDC_OFF_DIVISOR: divisor_reg <= pwdata[`SDC_DIV_W-1:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sticky flags; a read clears only what it returned, so a new event wins
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      ring_prev_reg <= 1'b1;
      ring_edge_reg <= 1'b0;
      overrun_reg <= 1'b0;
      irq_stat_reg <= '0;
    end else begin
      ring_prev_reg <= ring_s;
      ring_edge_reg <= (ring_edge_reg && !(rd_msr && prdata[`SDC_MSR_RING_EDGE]))
                       || (ring_prev_reg && !ring_s);
      overrun_reg <= (overrun_reg && !(rd_lsr && prdata[`SDC_LSR_OVERRUN]))
                     || (rx_push && rx_full);
      irq_stat_reg <= (irq_stat_reg & ~(rd_irq ? prdata[`SDC_IRQ_W-1:0] : '0))
                      | {rx_push && rx_full, ring_prev_reg && !ring_s,
                         tx_pop, rx_push && !rx_full};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // transmitter: free baud tick, start, eight data bits lsb first, stop
  assign tx_tick = (tx_cnt_reg == '0);
  assign tx_pop = tx_tick && (tx_state_reg == SDC_TX_IDLE) && tx_enable_reg && !tx_empty;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      tx_cnt_reg <= '0;
      tx_state_reg <= SDC_TX_IDLE;
      tx_bit_reg <= 4'h0;
      tx_shift_reg <= 8'h00;
      tx_line_reg <= 1'b1;
    end else begin
      tx_cnt_reg <= tx_tick ? divisor_reg : tx_cnt_reg - 1'b1;
      if (tx_tick) begin
        case (tx_state_reg)
          SDC_TX_IDLE: begin
            tx_line_reg <= 1'b1;
            if (tx_pop) begin
              tx_shift_reg <= tx_head;
              tx_state_reg <= SDC_TX_START;
            end
          end
          SDC_TX_START: begin
            tx_line_reg <= 1'b0;
            tx_bit_reg <= 4'h0;
            tx_state_reg <= SDC_TX_DATA;
          end
          SDC_TX_DATA: begin
            tx_line_reg <= tx_shift_reg[0];
            tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
            tx_bit_reg <= tx_bit_reg + 1'b1;
            if (tx_bit_reg == `SDC_CHAR_BITS - 1'b1) begin
              tx_state_reg <= SDC_TX_STOP;
            end
          end
          SDC_TX_STOP: begin
            tx_line_reg <= 1'b1;
            tx_state_reg <= SDC_TX_IDLE;
          end
          default: tx_state_reg <= SDC_TX_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // receiver: half-bit delay to centre, then one sample per bit time
  assign rx_push = (rx_state_reg == SDC_RX_STOP) && (rx_cnt_reg == '0) && rx_line;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rx_state_reg <= SDC_RX_IDLE;
      rx_cnt_reg <= '0;
      rx_bit_reg <= 4'h0;
      rx_shift_reg <= 8'h00;
    end else begin
      if (rx_cnt_reg != '0) begin
        rx_cnt_reg <= rx_cnt_reg - 1'b1;
      end
      case (rx_state_reg)
        SDC_RX_IDLE: if (!rx_line) begin // low is space: start bit
          rx_cnt_reg <= {1'b0, divisor_reg[`SDC_DIV_W-1:1]};
          rx_state_reg <= SDC_RX_START;
        end
        SDC_RX_START: if (rx_cnt_reg == '0) begin
          rx_cnt_reg <= divisor_reg;
          rx_bit_reg <= 4'h0;
          rx_state_reg <= rx_line ? SDC_RX_IDLE : SDC_RX_DATA;
        end
        SDC_RX_DATA: if (rx_cnt_reg == '0) begin
          rx_shift_reg <= {rx_line, rx_shift_reg[7:1]}; // high is mark, a one
          rx_bit_reg <= rx_bit_reg + 1'b1;
          rx_cnt_reg <= divisor_reg;
          if (rx_bit_reg == `SDC_CHAR_BITS - 1'b1) begin
            rx_state_reg <= SDC_RX_STOP;
          end
        end
        SDC_RX_STOP: if (rx_cnt_reg == '0) begin
          rx_state_reg <= SDC_RX_IDLE; // bad stop bit drops the character
        end
        default: rx_state_reg <= SDC_RX_IDLE;
      endcase
    end
  end

  // time-out: data waiting with no push or pop for a few character times
  always_ff @(posedge mclk) begin
    if (!rstn || rx_empty || rx_push || rd_data) begin
      timeout_reg <= 8'h00;
    end else if (tx_tick && !rx_timeout) begin
      timeout_reg <= timeout_reg + 1'b1;
    end
  end
  assign rx_timeout = (timeout_reg == `SDC_TIMEOUT_BITS);

  ////////////////////////////////////////////////////////////////////////////////
  // dma request pins, active low; mode 1 holds its level between the two events
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rx_dma_request_n_ch0 <= 1'b1;
      tx_dma_request_n_ch0 <= 1'b0;
    end else begin
      if (!mode1) begin
        rx_dma_request_n_ch0 <= rx_empty;
        tx_dma_request_n_ch0 <= !tx_empty;
      end else begin
        if (rx_empty) begin
          rx_dma_request_n_ch0 <= 1'b1;
        end else if (rx_count >= trig_level || rx_timeout) begin
          rx_dma_request_n_ch0 <= 1'b0;
        end
        if (tx_empty) begin
          tx_dma_request_n_ch0 <= 1'b0;
        end else if (tx_full) begin
          tx_dma_request_n_ch0 <= 1'b1;
        end
      end
    end
  end

  // line, modem and interrupt pins; float releases them all
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      serial_out_ch0 <= 1'b1;
      modem_ctrl_out <= '0;
      irq <= 1'b0;
      pins_oe <= 1'b0;
    end else begin
      serial_out_ch0 <= (loop_en || !tx_enable_reg) ? 1'b1 : tx_line_reg;
      modem_ctrl_out <= modem_ctrl_reg[`SDC_MCR_OUT_MSB:0];
      irq <= |(irq_stat_reg & irq_mask_reg);
      pins_oe <= !float_s;
    end
  end
endmodule // sdc_channel

// ==== core/sdc_fifo.sv ====
// Purpose: character fifo used as receive and transmit buffer
// Assumes: push when full and pop when empty are ignored
// Notes: clr empties it in one cycle
module sdc_fifo #(
  parameter int W = 8,
  parameter int D = 16,
  parameter int AW = 4
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic clr,
  input wire logic push,
  input wire logic [W-1:0] push_data,
  input wire logic pop,
  output logic [W-1:0] head,
  output logic [AW:0] count,
  output logic full,
  output logic empty
);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wptr_reg;
  logic [AW-1:0] rptr_reg;
  logic [AW:0] count_reg;
  logic do_push;
  logic do_pop;

  assign do_push = push && !full;
  assign do_pop = pop && !empty;
  assign head = mem[rptr_reg];
  assign count = count_reg;
  assign full = (count_reg == (AW+1)'(D));
  assign empty = (count_reg == '0);

  // storage has no reset; only pointers define content
  always_ff @(posedge mclk) begin
    if (do_push) begin
      mem[wptr_reg] <= push_data;
    end
  end

  // pointers and occupancy
  always_ff @(posedge mclk) begin
    if (!rstn || clr) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (do_push) begin
        wptr_reg <= (wptr_reg == AW'(D-1)) ? '0 : wptr_reg + 1'b1;
      end
      if (do_pop) begin
        rptr_reg <= (rptr_reg == AW'(D-1)) ? '0 : rptr_reg + 1'b1;
      end
      if (do_push && !do_pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (do_pop && !do_push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule // sdc_fifo

// ==== core/sdc_params.svh ====
// Purpose: named offsets, field positions, reset values and timing counts of the serial channel
// Assumes: 32-bit apb data, byte addresses, one register per aligned word
// Notes: definitions only
`ifndef SDC_PARAMS_SVH
`define SDC_PARAMS_SVH

////////////////////////////////////////////////////////////////////////////////
// register byte offsets
`define SDC_OFF_DATA 8'h00
`define SDC_OFF_FIFO_CTRL 8'h04
`define SDC_OFF_CTRL 8'h08
`define SDC_OFF_MODEM_CTRL 8'h0c
`define SDC_OFF_LINE_STAT 8'h10
`define SDC_OFF_MODEM_STAT 8'h14
`define SDC_OFF_IRQ_STAT 8'h18
`define SDC_OFF_IRQ_MASK 8'h1c
`define SDC_OFF_DIVISOR 8'h20

////////////////////////////////////////////////////////////////////////////////
// field positions
`define SDC_FCR_FIFO_EN 0
`define SDC_FCR_RX_CLR 1
`define SDC_FCR_TX_CLR 2
`define SDC_FCR_DMA_MODE 3
`define SDC_FCR_TRIG_LSB 6
`define SDC_FCR_TRIG_MSB 7
`define SDC_CTL_TX_EN 0
`define SDC_MCR_LOOP 4
`define SDC_MCR_OUT_MSB 1
`define SDC_LSR_DATA_READY 0
`define SDC_LSR_OVERRUN 1
`define SDC_LSR_THR_EMPTY 5
`define SDC_LSR_TX_EMPTY 6
`define SDC_MSR_RING_EDGE 2
`define SDC_MSR_RING_STATE 6
`define SDC_IRQ_RX 0
`define SDC_IRQ_TX 1
`define SDC_IRQ_RING 2
`define SDC_IRQ_OVR 3

////////////////////////////////////////////////////////////////////////////////
// widths, reset values, counts
`define SDC_MCR_W 5
`define SDC_IRQ_W 4
`define SDC_DIV_W 16
`define SDC_MCR_RESET 5'h00
`define SDC_DIV_RESET 16'h000d
`define SDC_CHAR_BITS 4'h8
`define SDC_TIMEOUT_BITS 8'h28
`define SDC_TRIG_0 5'h01
`define SDC_TRIG_1 5'h04
`define SDC_TRIG_2 5'h08
`define SDC_TRIG_3 5'h0e

`endif

// ==== core/sdc_pkg.sv ====
// Purpose: shared types of the serial channel
// Assumes: nothing beyond the params header
// Notes: state enums only
package sdc_pkg;
  typedef enum logic [1:0] {SDC_TX_IDLE, SDC_TX_START, SDC_TX_DATA, SDC_TX_STOP} sdc_tx_state_t;
  typedef enum logic [1:0] {SDC_RX_IDLE, SDC_RX_START, SDC_RX_DATA, SDC_RX_STOP} sdc_rx_state_t;
endpackage

// ==== core/sdc_sync.sv ====
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs are asynchronous to mclk
// Notes: first stage is read only by the second stage
module sdc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] stage1_reg;

  // two stages, synchronous reset to a constant
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      stage1_reg <= RST;
      sync_out <= RST;
    end else begin
      stage1_reg <= async_in;
      sync_out <= stage1_reg;
    end
  end
endmodule // sdc_sync

// ==== testbench/sdc_channel_checker.sv ====
// Purpose: port-level assertions for the serial channel
// Assumes: one clock domain, rstn synchronous and active low
// Notes: bound into every sdc_channel instance
`include "sdc_params.svh"
module sdc_channel_checker (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic output_float,
  input wire logic serial_out_ch0,
  input wire logic rx_dma_request_n_ch0,
  input wire logic tx_dma_request_n_ch0,
  input wire logic [`SDC_MCR_OUT_MSB:0] modem_ctrl_out,
  input wire logic irq,
  input wire logic pins_oe
);
  ////////////////////////////////////////////////////////////////////////////////
  // bus answer timing
  property p_apb_answer;
    @(posedge mclk) disable iff (!rstn) psel && penable && !pready |=> pready;
  endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("no answer after access");
  property p_ready_pulse;
    @(posedge mclk) disable iff (!rstn) pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
  property p_err_data;
    @(posedge mclk) disable iff (!rstn) pready && pslverr |-> prdata == 32'h0;
  endproperty
  a_err_data: assert property (p_err_data) else $error("refused read gave data");
  ////////////////////////////////////////////////////////////////////////////////
  // reset levels: no disable, this checks the reset itself
  property p_reset_outs;
    @(posedge mclk) !rstn |=> serial_out_ch0 && rx_dma_request_n_ch0 && !irq && !pins_oe
      && modem_ctrl_out == '0;
  endproperty
  a_reset_outs: assert property (p_reset_outs) else $error("pin wrong in reset");
  property p_tx_reset;
    @(posedge mclk) !rstn |=> !tx_dma_request_n_ch0;
  endproperty
  a_tx_reset: assert property (p_tx_reset) else $error("tx request high in reset");
  ////////////////////////////////////////////////////////////////////////////////
  // float control: two sync flops plus the enable flop
  property p_float_off;
    @(posedge mclk) disable iff (!rstn) output_float [*3] |=> !pins_oe;
  endproperty
  a_float_off: assert property (p_float_off) else $error("pins not released");
  property p_float_on;
    @(posedge mclk) disable iff (!rstn) !output_float [*4] |=> pins_oe;
  endproperty
  a_float_on: assert property (p_float_on) else $error("pins not driven");
  ////////////////////////////////////////////////////////////////////////////////
  // requests only go inactive as a result of a bus access
  property p_rx_rise;
    @(posedge mclk) disable iff (!rstn)
      $rose(rx_dma_request_n_ch0) |-> $past(pready, 1) || $past(pready, 2) || $past(pready, 3);
  endproperty
  a_rx_rise: assert property (p_rx_rise) else $error("rx request rose unprompted");
  property p_tx_rise;
    @(posedge mclk) disable iff (!rstn)
      $rose(tx_dma_request_n_ch0) |-> $past(pready, 1) || $past(pready, 2) || $past(pready, 3);
  endproperty
  a_tx_rise: assert property (p_tx_rise) else $error("tx request rose unprompted");
endmodule // sdc_channel_checker

bind sdc_channel sdc_channel_checker sdc_channel_checker_inst (.mclk(mclk), .rstn(rstn),
  .psel(psel), .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .output_float(output_float), .serial_out_ch0(serial_out_ch0),
  .rx_dma_request_n_ch0(rx_dma_request_n_ch0), .tx_dma_request_n_ch0(tx_dma_request_n_ch0),
  .modem_ctrl_out(modem_ctrl_out), .irq(irq), .pins_oe(pins_oe));

// ==== testbench/sdc_channel_tb_top.sv ====
// Purpose: self-checking bench for the serial channel
// Assumes: divisor 3 gives four mclk per bit
// Notes: random bytes from an xorshift seeded with 21
`include "sdc_params.svh"
module sdc_channel_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BIT = 4;
  logic mclk = 1'b0;
  logic rstn, psel, penable, pwrite, pready, pslverr, ring_n, output_float, junk, sin, sout;
  logic rx_n, tx_n, irq, pins_oe, rd_err;
  logic [7:0] paddr, b, got;
  logic [31:0] pwdata, prdata, rd_data, s = 32'd21;
  logic [1:0] mco;
  logic [7:0] bq [16];
  int mismatches = 0;
  int num_checks = 0;
  ////////////////////////////////////////////////////////////////////////////////
  always #20 mclk = ~mclk;
  sdc_channel #(.FIFO_DEPTH(16), .FIFO_AW(4)) sdc_channel_inst (.mclk(mclk), .rstn(rstn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .serial_in_ch0(sin),
    .ring_indicator_n_ch0(ring_n), .output_float(output_float), .serial_out_ch0(sout),
    .rx_dma_request_n_ch0(rx_n), .tx_dma_request_n_ch0(tx_n), .modem_ctrl_out(mco),
    .irq(irq), .pins_oe(pins_oe));
  sdc_serial_line_model #(.BIT_CYCLES(BIT)) sdc_serial_line_model_inst (.mclk(mclk),
    .junk(junk), .serial_in_ch0(sin));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] xs();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s[7:0];
  endfunction
  function automatic logic pin(input int sel);
    case (sel)
      0: return rx_n;
      1: return tx_n;
      2: return irq;
      default: return pins_oe;
    endcase
  endfunction
  task automatic complete_run();
    if (mismatches == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic timeout();
    mismatches++;
    $display("Error %0t: wait ran out", $time);
    complete_run();
  endtask
  task automatic chk_bit(input logic g, input logic e);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("Error %0t: pin %b expected %b", $time, g, e);
    end
  endtask
  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("Error %0t: value %h expected %h", $time, g, e);
    end
  endtask
  // apb master: setup, access, hold until ready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) timeout();
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk_word(rd_data, e);
  endtask
  task automatic wait_lvl(input int sel, input logic v);
    int n;
    for (n = 0; n < 2000 && pin(sel) !== v; n++) @(posedge mclk);
    if (n >= 2000) timeout();
  endtask
  // decode one frame from the serial output, sampling mid-bit
  task automatic rx_frame(output logic [7:0] c);
    int n;
    for (n = 0; n < 2000 && sout !== 1'b0; n++) @(posedge mclk);
    if (n >= 2000) timeout();
    repeat (BIT + BIT / 2) @(posedge mclk);
    for (int i = 0; i < 8; i++) begin
      c[i] = sout;
      repeat (BIT) @(posedge mclk);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {rstn, psel, penable, pwrite, junk, output_float} = 6'h0;
    ring_n = 1'b1;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    rd(`SDC_OFF_DIVISOR, 32'h0000000d);
    rd(8'hfc, 32'h0);
    chk_bit(rd_err, 1'b1);
    apb(1'b1, `SDC_OFF_DIVISOR, BIT - 1);
    // dma bit without fifo still signals single transfers
    apb(1'b1, `SDC_OFF_FIFO_CTRL, 32'h08);
    b = xs();
    apb(1'b1, `SDC_OFF_DATA, {24'h0, b});
    repeat (2) @(posedge mclk);
    chk_bit(tx_n, 1'b1);
    chk_bit(sout, 1'b1);
    apb(1'b1, `SDC_OFF_CTRL, 32'h1);
    rx_frame(got);
    chk_word({24'h0, got}, {24'h0, b});
    wait_lvl(1, 1'b0);
    // burst mode transmit: request holds low until completely full
    apb(1'b1, `SDC_OFF_CTRL, 32'h0);
    apb(1'b1, `SDC_OFF_FIFO_CTRL, 32'h0d);
    for (int i = 0; i < 16; i++) begin
      bq[i] = xs();
      apb(1'b1, `SDC_OFF_DATA, {24'h0, bq[i]});
      if (i == 14) chk_bit(tx_n, 1'b0);
    end
    repeat (2) @(posedge mclk);
    chk_bit(tx_n, 1'b1);
    apb(1'b1, `SDC_OFF_CTRL, 32'h1);
    rx_frame(got);
    chk_word({24'h0, got}, {24'h0, bq[0]});
    chk_bit(tx_n, 1'b1);
    wait_lvl(1, 1'b0);
    // single-transfer receive; dma bit and trigger 14 without fifo must not delay it
    apb(1'b1, `SDC_OFF_FIFO_CTRL, 32'hc8);
    for (int k = 0; k < 3; k++) begin
      b = xs();
      sdc_serial_line_model_inst.send_byte(b);
      repeat (6) @(posedge mclk);
      chk_bit(rx_n, 1'b0);
      rd(`SDC_OFF_DATA, {24'h0, b});
      repeat (2) @(posedge mclk);
      chk_bit(rx_n, 1'b1);
    end
    // burst receive, trigger of four: time-out first, then level
    apb(1'b1, `SDC_OFF_FIFO_CTRL, 32'h4b);
    for (int k = 0; k < 3; k++) sdc_serial_line_model_inst.send_byte(bq[k]);
    chk_bit(rx_n, 1'b1);
    wait_lvl(0, 1'b0);
    for (int k = 0; k < 3; k++) rd(`SDC_OFF_DATA, {24'h0, bq[k]});
    repeat (2) @(posedge mclk);
    chk_bit(rx_n, 1'b1);
    for (int k = 0; k < 4; k++) sdc_serial_line_model_inst.send_byte(bq[k + 4]);
    repeat (8) @(posedge mclk);
    chk_bit(rx_n, 1'b0);
    for (int k = 0; k < 4; k++) rd(`SDC_OFF_DATA, {24'h0, bq[k + 4]});
    // loop mode with a noisy external input
    apb(1'b1, `SDC_OFF_FIFO_CTRL, 32'h0);
    apb(1'b1, `SDC_OFF_MODEM_CTRL, 32'h13);
    junk <= 1'b1;
    b = xs();
    apb(1'b1, `SDC_OFF_DATA, {24'h0, b});
    chk_word(32'(mco), 32'h3);
    wait_lvl(0, 1'b0);
    chk_bit(sout, 1'b1);
    rd(`SDC_OFF_DATA, {24'h0, b});
    junk <= 1'b0;
    // reset in mid-run clears modem control and line status except the two transmitter empty bits
    rstn <= 1'b0;
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    rd(`SDC_OFF_MODEM_CTRL, 32'h0);
    chk_word(32'(mco), 32'h0);
    rd(`SDC_OFF_LINE_STAT, (32'h1 << `SDC_LSR_THR_EMPTY) | (32'h1 << `SDC_LSR_TX_EMPTY));
    // ring falling edge: flag, state, interrupt raise, clear and mask
    apb(1'b1, `SDC_OFF_IRQ_MASK, 32'h1 << `SDC_IRQ_RING);
    ring_n <= 1'b0;
    wait_lvl(2, 1'b1);
    rd(`SDC_OFF_MODEM_STAT, 32'h44);
    rd(`SDC_OFF_MODEM_STAT, 32'h40);
    rd(`SDC_OFF_IRQ_STAT, 32'h1 << `SDC_IRQ_RING);
    repeat (2) @(posedge mclk);
    chk_bit(irq, 1'b0);
    apb(1'b1, `SDC_OFF_IRQ_MASK, 32'h0);
    ring_n <= 1'b1;
    repeat (6) @(posedge mclk);
    ring_n <= 1'b0;
    repeat (8) @(posedge mclk);
    chk_bit(irq, 1'b0);
    rd(`SDC_OFF_MODEM_STAT, 32'h44);
    // float control
    output_float <= 1'b1;
    wait_lvl(3, 1'b0);
    output_float <= 1'b0;
    wait_lvl(3, 1'b1);
    complete_run();
  end
endmodule // sdc_channel_tb_top

// ==== testbench/sdc_serial_line_model.sv ====
// Purpose: far end of the serial line, sends 8N1 characters
// Assumes: bit time is BIT_CYCLES mclk cycles
// Notes: junk makes the line toggle every cycle, for loop tests
module sdc_serial_line_model #(
  parameter int BIT_CYCLES = 4
) (
  input wire logic mclk,
  input wire logic junk,
  output logic serial_in_ch0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic line_reg = 1'b1;
  logic toggle_reg = 1'b0;
  // changing pattern so a gated input cannot pass by luck
  always @(posedge mclk) begin
    toggle_reg <= ~toggle_reg;
  end
  assign serial_in_ch0 = junk ? toggle_reg : line_reg;
  // idle high is mark, start bit space, lsb first
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge mclk);
      line_reg <= frame[i];
      repeat (BIT_CYCLES - 1) @(posedge mclk);
    end
  endtask
endmodule // sdc_serial_line_model
